// ===== flyback_pkg.sv
package flyback_pkg;

  // ************************************************************
  // Clock and counter types
  // ************************************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_NS = 40;

  typedef logic [26:0] tcount_t;
  typedef logic [15:0] scount_t;
  typedef logic [23:0] phase_t;
  typedef logic [3:0]  evcount_t;

  // ************************************************************
  // Long times (module parameters take these as defaults)
  // ************************************************************
  localparam int unsigned ON_WINDOW_MS    = 82;
  localparam int unsigned OVERLOAD_MS     = 80;
  localparam int unsigned OFF_PERIOD_MS   = 1000;
  localparam int unsigned SKIP_TIMEOUT_MS = 1;
  localparam int unsigned OUT_RESTART_MS  = 64;
  localparam int unsigned SS_RAMP_MS      = 10;
  localparam int unsigned NOISE_HI_NS     = 200_000;

  localparam int unsigned ON_WINDOW_CYC    = ON_WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned OVERLOAD_CYC     = OVERLOAD_MS * (CLK_HZ / 1000);
  localparam int unsigned OFF_PERIOD_CYC   = OFF_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned SKIP_TIMEOUT_CYC = SKIP_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned OUT_RESTART_CYC  = OUT_RESTART_MS * (CLK_HZ / 1000);
  localparam int unsigned SS_RAMP_CYC      = SS_RAMP_MS * (CLK_HZ / 1000);
  localparam int unsigned NOISE_HI_CYC     = NOISE_HI_NS / CLK_NS;

  // ************************************************************
  // Short times
  // ************************************************************
  localparam int unsigned SOA_SKIP_NS    = 25_000;
  localparam int unsigned FAST_REQ_NS    = 9_090;
  localparam int unsigned PAIR_NS        = 30_000;
  localparam int unsigned FWD_TIMEOUT_NS = 30_000;
  localparam int unsigned NOISE_LO_NS    = 83_000;
  localparam int unsigned BLANK_LIMIT_NS = 500;
  localparam int unsigned MIN_OFF_NS     = 2_500;
  localparam int unsigned MAX_ON_NS      = 10_000;

  localparam int unsigned SOA_SKIP_CYC    = SOA_SKIP_NS / CLK_NS;
  localparam int unsigned FAST_REQ_CYC    = FAST_REQ_NS / CLK_NS;
  localparam int unsigned PAIR_CYC        = PAIR_NS / CLK_NS;
  localparam int unsigned FWD_TIMEOUT_CYC = FWD_TIMEOUT_NS / CLK_NS;
  localparam int unsigned NOISE_LO_CYC    = (NOISE_LO_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BLANK_LIMIT_CYC =
    (BLANK_LIMIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MIN_OFF_CYC     = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MAX_ON_CYC      = MAX_ON_NS / CLK_NS;

  // ************************************************************
  // Frequencies and the request rate accumulator
  // ************************************************************
  localparam int unsigned   STARTUP_SWITCH_FREQ = 25_000;
  localparam int unsigned   MAX_REQUEST_FREQ    = 100_000;
  localparam int unsigned   START_PERIOD_CYC    = CLK_HZ / STARTUP_SWITCH_FREQ;
  localparam longint        PHASE_ONE           = 64'd16_777_216;
  localparam int unsigned   INC_START =
    int'((longint'(STARTUP_SWITCH_FREQ) * PHASE_ONE) / CLK_HZ);
  localparam int unsigned   INC_MAX   =
    int'((longint'(MAX_REQUEST_FREQ) * PHASE_ONE) / CLK_HZ);
  localparam int unsigned   RAMP_DIV  = SS_RAMP_CYC / (INC_MAX - INC_START);

  // ************************************************************
  // Consecutive event limits
  // ************************************************************
  localparam int unsigned SOA_CONSEC      = 2;
  localparam int unsigned UNANSWERED_MAX  = 8;
  localparam int unsigned UNREQUESTED_MAX = 4;

  // ************************************************************
  // State machines
  // ************************************************************
  typedef enum logic [1:0] {
    P_AUTO   = 2'b00,
    P_LISTEN = 2'b01,
    P_SLAVE  = 2'b10,
    P_OFF    = 2'b11
  } prim_state_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_HS    = 2'b01,
    S_CTRL  = 2'b10,
    S_QUIET = 2'b11
  } sec_state_t;

  localparam int unsigned NUM_PINS = 12;

endpackage

// ===== pin_sync_if.sv
`timescale 1ns/10ps
`default_nettype none

interface pin_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

`default_nettype wire

// ===== pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic mclk,
  input  wire logic resetn,
  pin_sync_if.sync  port
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;
  logic [W-1:0] clean_q;

  // ************************************************************
  // Three stages; a level is taken only once stages two and three agree
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          stage1_q[i] <= 1'b0;
          stage2_q[i] <= 1'b0;
          stage3_q[i] <= 1'b0;
          clean_q[i]  <= 1'b0;
        end else begin
          stage1_q[i] <= port.raw[i];
          stage2_q[i] <= stage1_q[i];
          stage3_q[i] <= stage2_q[i];
          if (stage2_q[i] == stage3_q[i]) begin
            clean_q[i] <= stage3_q[i];
          end
        end
      end
    end
  endgenerate

  assign port.clean = clean_q;

endmodule // pin_sync

`default_nettype wire

// ===== flyback_cycle_control.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Two early limit cycles skip 25 us
// - Line reset clears pending auto-restart
// - Lost link: auto-restart, then restart switching
// - No feedback within on-window: auto-restart
// - Secondary in control: requests alone start cycles
// - 8 unanswered or 4 unrequested: rehandshake
// - Resumed primary returns to start-up, listens
// - Wait 82 ms; 30 us pair gives slave
// - No pair heard: switch autonomously
// - Slave gate inhibited 83 to 200 us after conduction
// - Rectifier on at fwd fall, DCM off below zero
// - CCM: rectifier off with next request
// - Requests honour minimum off and max rate
// - Start-up caps frequency and peak at 75%
// - Feedback short check armed after ramp
// - Armed feedback short stops requests
// - Request rate ramps linearly after handshake
// - Output low past timer: auto-restart
// - Regulated and QR programmed aborts ramp
// - Await fwd fall before request, 30 us timeout
// - Hot die lowers constant-current reference
// - Overload 80 ms or skip timeout: auto-restart
// - Auto-restart holds switching off full period
module flyback_cycle_control
  import flyback_pkg::*;
#(
  parameter tcount_t ON_WINDOW    = tcount_t'(ON_WINDOW_CYC),
  parameter tcount_t OVERLOAD     = tcount_t'(OVERLOAD_CYC),
  parameter tcount_t OFF_PERIOD   = tcount_t'(OFF_PERIOD_CYC),
  parameter tcount_t SKIP_TIMEOUT = tcount_t'(SKIP_TIMEOUT_CYC),
  parameter tcount_t OUT_RESTART  = tcount_t'(OUT_RESTART_CYC),
  parameter tcount_t SS_RAMP      = tcount_t'(SS_RAMP_CYC),
  parameter scount_t NOISE_HI     = scount_t'(NOISE_HI_CYC)
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic forwardWindingSense,
  input  wire logic primaryPeakLimit,
  input  wire logic lineReset,
  input  wire logic secondaryPowered,
  input  wire logic loadDemand,
  input  wire logic feedbackShortLow,
  input  wire logic outputRestartLow,
  input  wire logic outputRegulated,
  input  wire logic qrProgrammed,
  input  wire logic rectifierNegative,
  input  wire logic ccmMode,
  input  wire logic dieHot,
  output var  logic primaryGate_q,
  output var  logic syncRectGate_q,
  output var  logic cycleRequest_q,
  output var  logic peakCap75_q,
  output var  logic ccRefReduced_q,
  output var  logic autoRestart_q,
  output var  logic slaveMode_q,
  output var  logic secInControl_q
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  pin_sync_if #(.W(NUM_PINS)) pinBus ();

  assign pinBus.raw = {forwardWindingSense, primaryPeakLimit, lineReset,
                       secondaryPowered, loadDemand, feedbackShortLow,
                       outputRestartLow, outputRegulated, qrProgrammed,
                       rectifierNegative, ccmMode, dieHot};

  pin_sync #(.W(NUM_PINS)) u_pin_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .port   (pinBus.sync)
  );

  logic forward_winding_sense, peak, lineRst, secPwr, demand, fbLow;
  logic outLow, regulated, qrDone, rectNeg, ccm, hot;
  assign {forward_winding_sense, peak, lineRst, secPwr, demand, fbLow,
          outLow, regulated, qrDone, rectNeg, ccm, hot} = pinBus.clean;

  logic fwdPrev_q;
  logic fwdFall;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fwdPrev_q <= 1'b0;
    end else begin
      fwdPrev_q <= forward_winding_sense;
    end
  end
  assign fwdFall = fwdPrev_q & ~forward_winding_sense;

  // ************************************************************
  // Primary: switch gate, SOA skip and noise band
  // ************************************************************
  prim_state_t stateP_q, stateP_d;
  scount_t     onTimer_q, sinceOff_q, autoTimer_q, soaSkip_q;
  evcount_t    soaCount_q;
  logic        gateStart, gateEnd, noiseBand, soaBusy, earlyLimit;

  assign noiseBand = (sinceOff_q >= scount_t'(NOISE_LO_CYC)) &&
                     (sinceOff_q < NOISE_HI);
  assign soaBusy   = (soaSkip_q != '0);
  assign earlyLimit = onTimer_q < scount_t'(BLANK_LIMIT_CYC);
  assign gateEnd   = primaryGate_q &&
                     (peak || onTimer_q == scount_t'(MAX_ON_CYC - 1));

  always_comb begin
    gateStart = 1'b0;
    if (!primaryGate_q && !soaBusy && stateP_q == stateP_d) begin
      if (stateP_q == P_SLAVE) begin
        gateStart = cycleRequest_q && !noiseBand;
      end else if (stateP_q == P_AUTO) begin
        gateStart = autoTimer_q >= scount_t'(START_PERIOD_CYC - 1);
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      primaryGate_q <= 1'b0;
      onTimer_q     <= '0;
    end else if (stateP_d == P_OFF || stateP_d == P_LISTEN) begin
      primaryGate_q <= 1'b0;
      onTimer_q     <= '0;
    end else if (gateStart) begin
      primaryGate_q <= 1'b1;
      onTimer_q     <= '0;
    end else if (gateEnd) begin
      primaryGate_q <= 1'b0;
    end else if (primaryGate_q) begin
      onTimer_q <= onTimer_q + 1'b1;
    end
  end

  // Saturating count from the end of the last conduction
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sinceOff_q <= '1;
    end else if (primaryGate_q) begin
      sinceOff_q <= '0;
    end else if (sinceOff_q != '1) begin
      sinceOff_q <= sinceOff_q + 1'b1;
    end
  end

  // Autonomous rate is bounded by the start-up frequency
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      autoTimer_q <= '0;
    end else if (gateStart || stateP_q != P_AUTO) begin
      autoTimer_q <= '0;
    end else if (autoTimer_q != '1) begin
      autoTimer_q <= autoTimer_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      soaCount_q <= '0;
      soaSkip_q  <= '0;
    end else if (gateEnd) begin
      if (!earlyLimit) begin
        soaCount_q <= '0;
      end else if (soaCount_q == evcount_t'(SOA_CONSEC - 1)) begin
        soaCount_q <= '0;
        soaSkip_q  <= scount_t'(SOA_SKIP_CYC);
      end else begin
        soaCount_q <= soaCount_q + 1'b1;
      end
    end else if (soaBusy) begin
      soaSkip_q <= soaSkip_q - 1'b1;
    end
  end

  // ************************************************************
  // Primary: handshake pair, overload and request silence
  // ************************************************************
  scount_t pairGap_q, reqGap_q;
  logic    pairArmed_q, pairSeen;
  tcount_t stateTimer_q, fastTimer_q, idleTimer_q;

  assign pairSeen = cycleRequest_q && pairArmed_q &&
                    pairGap_q <= scount_t'(PAIR_CYC);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pairArmed_q <= 1'b0;
      pairGap_q   <= '0;
    end else if (cycleRequest_q) begin
      pairArmed_q <= !pairSeen;
      pairGap_q   <= '0;
    end else if (pairGap_q != '1) begin
      pairGap_q <= pairGap_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reqGap_q    <= '1;
      fastTimer_q <= '0;
      idleTimer_q <= '0;
    end else begin
      if (cycleRequest_q) begin
        reqGap_q    <= '0;
        idleTimer_q <= '0;
        if (reqGap_q >= scount_t'(FAST_REQ_CYC)) begin
          fastTimer_q <= '0;
        end
      end else begin
        if (reqGap_q != '1) begin
          reqGap_q <= reqGap_q + 1'b1;
        end
        if (idleTimer_q != '1) begin
          idleTimer_q <= idleTimer_q + 1'b1;
        end
        if (reqGap_q >= scount_t'(FAST_REQ_CYC)) begin
          fastTimer_q <= '0;
        end
      end
      if (reqGap_q < scount_t'(FAST_REQ_CYC) && fastTimer_q != '1) begin
        fastTimer_q <= fastTimer_q + 1'b1;
      end
      if (stateP_q != P_SLAVE) begin
        fastTimer_q <= '0;
        idleTimer_q <= '0;
      end
    end
  end

  always_comb begin
    stateP_d = stateP_q;
    case (stateP_q)
      P_AUTO: begin
        if (pairSeen) begin
          stateP_d = P_SLAVE;
        end else if (stateTimer_q >= ON_WINDOW) begin
          stateP_d = P_OFF;
        end
      end
      P_LISTEN: begin
        if (pairSeen) begin
          stateP_d = P_SLAVE;
        end else if (stateTimer_q >= ON_WINDOW) begin
          stateP_d = P_AUTO;
        end
      end
      P_SLAVE: begin
        if (fastTimer_q >= OVERLOAD || idleTimer_q >= SKIP_TIMEOUT) begin
          stateP_d = P_OFF;
        end
      end
      default: begin
        if (stateTimer_q >= OFF_PERIOD) begin
          stateP_d = P_LISTEN;
        end
      end
    endcase
    if (lineRst) begin
      stateP_d = P_LISTEN;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stateP_q     <= P_AUTO;
      stateTimer_q <= '0;
      autoRestart_q <= 1'b0;
      slaveMode_q  <= 1'b0;
    end else begin
      stateP_q      <= stateP_d;
      autoRestart_q <= (stateP_d == P_OFF);
      slaveMode_q   <= (stateP_d == P_SLAVE);
      // Feedback in the on-window restarts it
      if (stateP_d != stateP_q || lineRst ||
          (stateP_q == P_AUTO && cycleRequest_q)) begin
        stateTimer_q <= '0;
      end else if (stateTimer_q != '1) begin
        stateTimer_q <= stateTimer_q + 1'b1;
      end
    end
  end

  // ************************************************************
  // Secondary: handshake and supervision
  // ************************************************************
  sec_state_t stateS_d, stateS_q;
  scount_t    hsTimer_q, awaitTimer_q, sinceFwd_q;
  evcount_t   unanswered_q, unrequested_q;
  logic       awaitFwd_q, credit_q, reqIssue, hsPulse, timeoutHit;
  logic       fbArmed_q, outOk_q;
  tcount_t    rampTimer_q, outTimer_q;
  phase_t     phase_q;
  logic [16:0] inc_q;
  logic [2:0]  rampDiv_q;
  logic [24:0] phaseSum;

  assign hsPulse  = stateS_q == S_HS &&
                    (hsTimer_q == '0 || hsTimer_q == scount_t'(PAIR_CYC));
  assign reqIssue = stateS_q == S_CTRL && stateS_d == S_CTRL && demand &&
                    credit_q && !awaitFwd_q &&
                    sinceFwd_q >= scount_t'(MIN_OFF_CYC);
  assign timeoutHit = awaitFwd_q &&
                      awaitTimer_q >= scount_t'(FWD_TIMEOUT_CYC - 1);

  always_comb begin
    stateS_d = stateS_q;
    case (stateS_q)
      S_IDLE: begin
        stateS_d = S_HS;
      end
      S_HS: begin
        if (hsTimer_q == scount_t'(PAIR_CYC)) begin
          stateS_d = S_CTRL;
        end
      end
      S_CTRL: begin
        if (unanswered_q >= evcount_t'(UNANSWERED_MAX) ||
            unrequested_q >= evcount_t'(UNREQUESTED_MAX)) begin
          stateS_d = S_HS;
        end else if ((fbArmed_q && fbLow) ||
                     (!outOk_q && outTimer_q >= OUT_RESTART)) begin
          stateS_d = S_QUIET;
        end
      end
      default: begin
        // Primary back on its own: try to take over again
        if (fwdFall) begin
          stateS_d = S_HS;
        end
      end
    endcase
    if (!secPwr) begin
      stateS_d = S_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stateS_q       <= S_IDLE;
      hsTimer_q      <= '0;
      secInControl_q <= 1'b0;
      cycleRequest_q <= 1'b0;
    end else begin
      stateS_q       <= stateS_d;
      secInControl_q <= (stateS_d == S_CTRL);
      cycleRequest_q <= hsPulse || reqIssue;
      if (stateS_q != S_HS) begin
        hsTimer_q <= '0;
      end else begin
        hsTimer_q <= hsTimer_q + 1'b1;
      end
    end
  end

  // Unanswered requests and unrequested cycles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awaitFwd_q    <= 1'b0;
      awaitTimer_q  <= '0;
      unanswered_q  <= '0;
      unrequested_q <= '0;
      sinceFwd_q    <= '1;
    end else if (stateS_q != S_CTRL) begin
      awaitFwd_q    <= 1'b0;
      unanswered_q  <= '0;
      unrequested_q <= '0;
      sinceFwd_q    <= '1;
    end else begin
      if (fwdFall) begin
        sinceFwd_q <= '0;
      end else if (sinceFwd_q != '1) begin
        sinceFwd_q <= sinceFwd_q + 1'b1;
      end
      if (reqIssue) begin
        awaitFwd_q   <= 1'b1;
        awaitTimer_q <= '0;
      end else if (awaitFwd_q && fwdFall) begin
        awaitFwd_q    <= 1'b0;
        unanswered_q  <= '0;
        unrequested_q <= '0;
      end else if (timeoutHit) begin
        awaitFwd_q   <= 1'b0;
        unanswered_q <= unanswered_q + 1'b1;
      end else if (awaitFwd_q) begin
        awaitTimer_q <= awaitTimer_q + 1'b1;
      end else if (fwdFall) begin
        unrequested_q <= unrequested_q + 1'b1;
      end
    end
  end

  // ************************************************************
  // Secondary: request rate ramp and fault timers
  // ************************************************************
  assign phaseSum = {1'b0, phase_q} + {8'h00, inc_q};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_q     <= '0;
      inc_q       <= 17'(INC_START);
      rampDiv_q   <= '0;
      rampTimer_q <= '0;
      fbArmed_q   <= 1'b0;
      credit_q    <= 1'b0;
    end else if (stateS_q != S_CTRL) begin
      phase_q     <= '0;
      inc_q       <= 17'(INC_START);
      rampDiv_q   <= '0;
      rampTimer_q <= '0;
      fbArmed_q   <= 1'b0;
      credit_q    <= 1'b0;
    end else begin
      phase_q <= phaseSum[23:0];
      // A new credit wins over the one being spent
      if (phaseSum[24]) begin
        credit_q <= 1'b1;
      end else if (reqIssue) begin
        credit_q <= 1'b0;
      end
      if (rampTimer_q >= SS_RAMP) begin
        fbArmed_q <= 1'b1;
      end else begin
        rampTimer_q <= rampTimer_q + 1'b1;
      end
      if (regulated && qrDone) begin
        inc_q <= 17'(INC_MAX);
      end else if (inc_q < 17'(INC_MAX)) begin
        if (rampDiv_q == 3'(RAMP_DIV - 1)) begin
          rampDiv_q <= '0;
          inc_q     <= inc_q + 1'b1;
        end else begin
          rampDiv_q <= rampDiv_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      outTimer_q <= '0;
      outOk_q    <= 1'b0;
    end else if (stateS_q != S_CTRL) begin
      outTimer_q <= '0;
      outOk_q    <= 1'b0;
    end else if (!outLow) begin
      outOk_q <= 1'b1;
    end else if (outTimer_q != '1) begin
      outTimer_q <= outTimer_q + 1'b1;
    end
  end

  // ************************************************************
  // Secondary: rectifier gate, thermal foldback, start-up cap
  // ************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncRectGate_q <= 1'b0;
    end else if (stateS_q != S_CTRL) begin
      syncRectGate_q <= 1'b0;
    end else if (fwdFall) begin
      syncRectGate_q <= 1'b1;
    end else if (ccm && reqIssue) begin
      syncRectGate_q <= 1'b0;
    end else if (!ccm && rectNeg) begin
      syncRectGate_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ccRefReduced_q <= 1'b0;
      peakCap75_q    <= 1'b1;
    end else begin
      ccRefReduced_q <= hot;
      peakCap75_q    <= (stateP_d != P_SLAVE) ||
                        (inc_q < 17'(INC_MAX));
    end
  end

endmodule // flyback_cycle_control

`default_nettype wire

// ===== flyback_cycle_props.sv
`timescale 1ns/10ps
`default_nettype none
module flyback_cycle_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic lineReset,
  input wire logic ccmMode,
  input wire logic dieHot,
  input wire logic primaryGate_q,
  input wire logic syncRectGate_q,
  input wire logic cycleRequest_q,
  input wire logic peakCap75_q,
  input wire logic ccRefReduced_q,
  input wire logic autoRestart_q,
  input wire logic slaveMode_q
);
  // ****************************************************
  // Helpers: synchroniser settling and gate off time
  // ****************************************************
  logic [3:0]  upCnt_q;
  int unsigned sinceOff_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) upCnt_q <= '0;
    else if (upCnt_q != 4'hF) upCnt_q <= upCnt_q + 4'h1;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) sinceOff_q <= 0;
    else if (primaryGate_q) sinceOff_q <= 0;
    else if (sinceOff_q < 9999) sinceOff_q <= sinceOff_q + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_pairEnd;
    $rose(slaveMode_q);
  endsequence
  sequence s_slaveStart;
    slaveMode_q && $rose(primaryGate_q);
  endsequence
  property p_pair; s_pairEnd |-> $past(cycleRequest_q); endproperty
  a_pair: assert property (p_pair) else $error("slave without pair");
  property p_pulse; cycleRequest_q |=> !cycleRequest_q [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("requests too close");
  property p_slaveGate; s_slaveStart |-> $past(cycleRequest_q); endproperty
  a_slaveGate: assert property (p_slaveGate) else $error("gate unasked");
  property p_noise;
    s_slaveStart |-> !(sinceOff_q inside {[2078:4997]});
  endproperty
  a_noise: assert property (p_noise) else $error("gate in noise band");
  property p_arOff; autoRestart_q |-> !$rose(primaryGate_q); endproperty
  a_arOff: assert property (p_arOff) else $error("gate in restart");
  property p_onMax; $rose(primaryGate_q) |-> ##[1:252] !primaryGate_q;
  endproperty
  a_onMax: assert property (p_onMax) else $error("gate stuck on");
  property p_ccm;
    upCnt_q > 4'h8 && ccmMode && $past(ccmMode, 6) && cycleRequest_q
      |=> !syncRectGate_q;
  endproperty
  a_ccm: assert property (p_ccm) else $error("rectifier on at request");
  property p_cap; !slaveMode_q && !$past(slaveMode_q) |-> peakCap75_q;
  endproperty
  a_cap: assert property (p_cap) else $error("peak not capped");
  property p_hot;
    upCnt_q > 4'h8 && dieHot && $past(dieHot, 6) |-> ccRefReduced_q;
  endproperty
  a_hot: assert property (p_hot) else $error("no thermal foldback");
  property p_line;
    upCnt_q > 4'h8 && lineReset && $past(lineReset, 6) |-> !autoRestart_q;
  endproperty
  a_line: assert property (p_line) else $error("restart kept");
endmodule // flyback_cycle_props
`default_nettype wire

// ===== flyback_partner.sv
`timescale 1ns/10ps
`default_nettype none
module flyback_partner (
  input  wire logic       mclk,
  input  wire logic       primaryGate_q,
  input  wire logic [7:0] limitAfter,
  output wire logic       forwardWindingSense,
  output wire logic       primaryPeakLimit,
  output wire logic       rectifierNegative
);
  int unsigned onCnt_q;
  int unsigned offCnt_q;
  always_ff @(posedge mclk) begin
    onCnt_q  <= primaryGate_q ? onCnt_q + 1 : 0;
    offCnt_q <= primaryGate_q ? 0 : (offCnt_q < 999 ? offCnt_q + 1 : 999);
  end
  // Winding swings negative while the switch conducts
  assign forwardWindingSense = !primaryGate_q;
  // Current ramp reaches the limit after a settable time
  assign primaryPeakLimit = primaryGate_q && onCnt_q >= limitAfter;
  assign rectifierNegative = !primaryGate_q && offCnt_q > 60;
endmodule // flyback_partner
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk = 0, resetn = 0, lineReset = 0, secondaryPowered = 0;
  logic loadDemand = 0, feedbackShortLow = 0, outputRestartLow = 0;
  logic outputRegulated = 0, qrProgrammed = 0, ccmMode = 0, dieHot = 0;
  logic [7:0] limitAfter = 8'hC8;
  wire logic forwardWindingSense, primaryPeakLimit, rectifierNegative;
  wire logic primaryGate_q, syncRectGate_q, cycleRequest_q, peakCap75_q;
  wire logic ccRefReduced_q, autoRestart_q, slaveMode_q, secInControl_q;
  int err_total = 0, compares = 0, cyc = 0, n;
  logic srSeen = 0;
  // Shortened timers keep the run to a few tens of thousands of cycles
  flyback_cycle_control #(.ON_WINDOW(27'h7D0), .OVERLOAD(27'hBB8),
    .OFF_PERIOD(27'h3E8), .SKIP_TIMEOUT(27'h1388), .OUT_RESTART(27'h7D0),
    .SS_RAMP(27'h1F4)) u_flyback_cycle_control (.*);
  flyback_partner u_flyback_partner (.*);
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (syncRectGate_q === 1'b1) srSeen = 1;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end
  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic check(string what, logic got, logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset();
    tick(8);
    check("cap", peakCap75_q, 1'b1);
    check("ar", autoRestart_q, 1'b0);
    resetn = 1;
  endtask
  task automatic t_startup();
    for (n = 0; n < 1100 && primaryGate_q !== 1'b1; n++) tick(1);
    check("autoGate", primaryGate_q, 1'b1);
    for (n = 0; n < 2200 && autoRestart_q !== 1'b1; n++) tick(1);
    check("arEntry", autoRestart_q, 1'b1);
    lineReset = 1;
    tick(8);
    check("arClear", autoRestart_q, 1'b0);
    lineReset = 0;
  endtask
  task automatic t_handshake();
    secondaryPowered = 1;
    loadDemand = 1;
    // Output starts low; it must rise before the output timer runs out
    outputRestartLow = 1;
    for (n = 0; n < 3000 && slaveMode_q !== 1'b1; n++) tick(1);
    check("slave", slaveMode_q, 1'b1);
    check("secCtrl", secInControl_q, 1'b1);
    check("capRamp", peakCap75_q, 1'b1);
    for (n = 0; n < 1100 && cycleRequest_q !== 1'b1; n++) tick(1);
    tick(1);
    check("answer", primaryGate_q, 1'b1);
    limitAfter = 8'h30;
    outputRestartLow = 0;
    // Regulation with QR programmed skips the rest of the slow ramp
    outputRegulated = 1;
    qrProgrammed = 1;
    tick(1500);
    check("capFree", peakCap75_q, 1'b0);
    check("outOk", secInControl_q, 1'b1);
    check("srOn", srSeen, 1'b1);
  endtask
  task automatic t_hotCcm();
    dieHot = 1;
    ccmMode = 1;
    tick(8);
    check("hot", ccRefReduced_q, 1'b1);
    dieHot = 0;
    tick(600);
    check("cool", ccRefReduced_q, 1'b0);
    ccmMode = 0;
  endtask
  task automatic t_fbShort();
    feedbackShortLow = 1;
    for (n = 0; n < 6000 && autoRestart_q !== 1'b1; n++) tick(1);
    check("shortAr", autoRestart_q, 1'b1);
    for (n = 0; n < 1200 && autoRestart_q === 1'b1; n++) tick(1);
    for (n = 0; n < 3500 && primaryGate_q !== 1'b1; n++) tick(1);
    check("restart", primaryGate_q, 1'b1);
  endtask
  initial begin
    t_reset();
    t_startup();
    t_handshake();
    t_hotCcm();
    t_fbShort();
    final_report();
  end
endmodule // testbench
bind flyback_cycle_control flyback_cycle_props u_flyback_cycle_props (.*);
`default_nettype wire
